// [src/rcs_pkg.sv]
// Shared constants and types of the rectifier control and status logic
package rcs_pkg;
   // Identifier levels are 8-bit ADC codes, 3.3 V full scale on slot/unit pins
   localparam int LVL_W = 8;
   localparam int SHELF_W = 10;
   // Slot and unit nominal codes, slot 1 at index 0 (3.00 V) down to slot 10 (0 V)
   localparam logic [LVL_W-1:0] POS_NOM [0:9] = '{8'he8, 8'hcf, 8'hb5, 8'h9c, 8'h82,
                                                 8'h68, 8'h4f, 8'h35, 8'h1c, 8'h00};
   // Pulled-up open pin code (3.3 V)
   localparam logic [LVL_W-1:0] POS_OPEN = 8'hff;
   // Shelf windows in 0.1 V units, shelf 1 at index 0
   localparam logic [SHELF_W-1:0] SHELF_MIN [0:9] = '{10'h017, 10'h02f, 10'h04a, 10'h05f,
      10'h076, 10'h08e, 10'h0a6, 10'h0be, 10'h0d5, 10'h0ee};
   localparam logic [SHELF_W-1:0] SHELF_MAX [0:9] = '{10'h01b, 10'h035, 10'h04c, 10'h069,
      10'h084, 10'h09e, 10'h0b8, 10'h0d2, 10'h0ec, 10'h107};
   // Setpoint in 0.1 V units, 44.0 V to 58.0 V from the programming pin, any 10-bit value from cmd.vset
   localparam int SP_W = 10;
   localparam logic [SP_W-1:0] SP_MIN = 10'h1b8;
   localparam logic [SP_W-1:0] SP_SPAN = 10'h08c;
   localparam logic [SP_W-1:0] SP_DEFAULT = 10'h21c;
   // Programming pin code above which the factory default applies (3.0 V)
   localparam logic [LVL_W-1:0] PROG_MAX = 8'he8;
   // I2C address prefix and broadcast address
   localparam logic [2:0] I2C_PREFIX = 3'h4;
   localparam logic [6:0] BCAST_ADDR = 7'h00;
   // Timing
   localparam int CLK_MHZ = 200;
   localparam int PG_PULSE_MS = 1;
   localparam int OTW_LEAD_S = 10;
   localparam longint PG_PULSE_CYC = longint'(PG_PULSE_MS) * CLK_MHZ * 1000;
   localparam longint OTW_LEAD_CYC = longint'(OTW_LEAD_S) * CLK_MHZ * 1000000;

   typedef struct packed {
      logic fan_fail;
      logic ot_shutdown;
      logic ov_shutdown;
      logic internal;
   } rcs_fault_t;

   typedef struct packed {
      logic valid;
      logic [3:0] num;
   } rcs_pos_t;

   typedef struct packed {
      logic valid;
      logic rd;
      logic [6:0] addr;
      logic cmd_vset;
      logic cmd_on;
      logic cmd_off;
      logic cmd_clear;
      logic [SP_W-1:0] vset;
   } rcs_cmd_t;
endpackage : rcs_pkg

// [src/rcs_pos_decode.sv]
// Quantizes a slot or unit position level into a position number
module rcs_pos_decode (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [rcs_pkg::LVL_W-1:0] level,
   output rcs_pkg::rcs_pos_t pos
);
   function automatic logic [rcs_pkg::LVL_W:0] mid(input int i);
      mid = ({1'b0, rcs_pkg::POS_NOM[i]} + {1'b0, rcs_pkg::POS_NOM[i+1]}) >> 1;
   endfunction : mid

   rcs_pkg::rcs_pos_t pos_d;

   always_comb begin
      pos_d = '0;
      if (level > rcs_pkg::POS_NOM[0] + ((rcs_pkg::POS_OPEN - rcs_pkg::POS_NOM[0]) >> 1)) begin
         pos_d.valid = 1'b0;
      end else begin
         pos_d.valid = 1'b1;
         pos_d.num = 4'ha;
         for (int i = 8; i >= 0; i--) begin
            if ({1'b0, level} > mid(i)) begin
               pos_d.num = 4'(i + 1);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos <= '0;
      end else begin
         pos <= pos_d;
      end
   end
endmodule : rcs_pos_decode

// [src/rcs_shelf_decode.sv]
// Decodes the shelf position level into a shelf number
module rcs_shelf_decode (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [rcs_pkg::SHELF_W-1:0] level,
   output rcs_pkg::rcs_pos_t pos
);
   rcs_pkg::rcs_pos_t pos_d;

   always_comb begin
      pos_d = '0;
      for (int i = 0; i < 10; i++) begin
         if (level >= rcs_pkg::SHELF_MIN[i] && level <= rcs_pkg::SHELF_MAX[i]) begin
            pos_d.valid = 1'b1;
            pos_d.num = 4'(i + 1);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos <= '0;
      end else begin
         pos <= pos_d;
      end
   end
endmodule : rcs_shelf_decode

// [src/rcs_top.sv]
// Rectifier control and status logic: addressing, setpoint, output gating, status pins
module rcs_top #(
   parameter longint PG_PULSE_CYC = rcs_pkg::PG_PULSE_CYC,
   parameter longint OTW_LEAD_CYC = rcs_pkg::OTW_LEAD_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic rs485_mode,
   input wire logic [3:0] i2c_pos_bits,
   input wire logic [rcs_pkg::LVL_W-1:0] unit_position_level,
   input wire logic [rcs_pkg::LVL_W-1:0] slot_position_level,
   input wire logic [rcs_pkg::SHELF_W-1:0] shelf_position_level,
   input wire logic [rcs_pkg::LVL_W-1:0] vprog_level,
   input wire logic on_off_n,
   input wire logic interlock_n,
   input wire rcs_pkg::rcs_cmd_t cmd,
   input wire logic out_in_reg,
   input wire logic out_near_drop,
   input wire logic overload,
   input wire rcs_pkg::rcs_fault_t faults,
   input wire logic overtemp,
   input wire logic high_line,
   input wire logic state_change,
   input wire logic comm_error,
   input wire logic selector_alert_n,
   output rcs_pkg::rcs_pos_t bay_position_level,
   output rcs_pkg::rcs_pos_t slot_pos,
   output rcs_pkg::rcs_pos_t shelf_pos,
   output logic cmd_accept,
   output logic invalid_cmd,
   output logic [rcs_pkg::SP_W-1:0] setpoint,
   output logic main_out_en,
   output logic overtemp_shutdown,
   output logic power_good_warn_n,
   output logic fault_n,
   output logic overtemp_warn_n,
   output logic power_limit_indicator,
   output logic combined_alert_n,
   output logic module_present
);
   logic [1:0] onoff_sync_q, ilk_sync_q, mode_sync_q;
   logic sw_owns_q;
   logic [rcs_pkg::SP_W-1:0] sw_sp_q, pin_sp_d;
   logic out_on_q, sw_off_q;
   logic pg_q, pg_tgl_q;
   logic [31:0] pg_cnt_q;
   logic [35:0] otw_cnt_q;
   logic ot_sd_q, otw_q, alert_q, fault_q, cap_q;
   logic addr_hit, bcast, slot_engaged;
   logic [rcs_pkg::LVL_W-1:0] unit_s1_q, unit_s2_q, slot_s1_q, slot_s2_q;
   logic [rcs_pkg::LVL_W-1:0] vprog_s1_q, vprog_s2_q;
   logic [rcs_pkg::SHELF_W-1:0] shelf_s1_q, shelf_s2_q;
   logic [3:0] pos_bits_s1_q, pos_bits_s2_q;

   // Level pins are static straps; a torn sample settles on the next clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         unit_s1_q <= '0;
         unit_s2_q <= '0;
      end else begin
         unit_s1_q <= unit_position_level;
         unit_s2_q <= unit_s1_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         slot_s1_q <= '0;
         slot_s2_q <= '0;
      end else begin
         slot_s1_q <= slot_position_level;
         slot_s2_q <= slot_s1_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shelf_s1_q <= '0;
         shelf_s2_q <= '0;
      end else begin
         shelf_s1_q <= shelf_position_level;
         shelf_s2_q <= shelf_s1_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         vprog_s1_q <= '0;
         vprog_s2_q <= '0;
      end else begin
         vprog_s1_q <= vprog_level;
         vprog_s2_q <= vprog_s1_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_bits_s1_q <= '0;
         pos_bits_s2_q <= '0;
      end else begin
         pos_bits_s1_q <= i2c_pos_bits;
         pos_bits_s2_q <= pos_bits_s1_q;
      end
   end

   rcs_pos_decode u_unit (
      .clk(clk),
      .arst_n(arst_n),
      .level(unit_s2_q),
      .pos(bay_position_level)
   );

   rcs_pos_decode u_slot (
      .clk(clk),
      .arst_n(arst_n),
      .level(slot_s2_q),
      .pos(slot_pos)
   );

   rcs_shelf_decode u_shelf (
      .clk(clk),
      .arst_n(arst_n),
      .level(shelf_s2_q),
      .pos(shelf_pos)
   );

   // Pin synchronisers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         onoff_sync_q <= 2'h3;
         ilk_sync_q <= 2'h3;
         mode_sync_q <= 2'h0;
      end else begin
         onoff_sync_q <= {onoff_sync_q[0], on_off_n};
         ilk_sync_q <= {ilk_sync_q[0], interlock_n};
         mode_sync_q <= {mode_sync_q[0], rs485_mode};
      end
   end

   // Address match
   always_comb begin
      bcast = (cmd.addr == rcs_pkg::BCAST_ADDR);
      addr_hit = (cmd.addr == {rcs_pkg::I2C_PREFIX, pos_bits_s2_q});
      if (mode_sync_q[1]) begin
         addr_hit = bay_position_level.valid && slot_pos.valid && shelf_pos.valid
                    && (cmd.addr == {3'h0, bay_position_level.num});
      end
   end

   // Command acceptance
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_accept <= 1'b0;
         invalid_cmd <= 1'b0;
      end else begin
         invalid_cmd <= cmd.valid && bcast && cmd.rd;
         cmd_accept <= cmd.valid && (addr_hit || (bcast && !cmd.rd));
      end
   end

   wire take = cmd.valid && !cmd.rd && (addr_hit || bcast);

   always_comb begin
      pin_sp_d = rcs_pkg::SP_MIN + rcs_pkg::SP_W'((32'(vprog_s2_q) * 32'(rcs_pkg::SP_SPAN))
                 / 32'(rcs_pkg::PROG_MAX));
      if (vprog_s2_q > rcs_pkg::PROG_MAX) begin
         pin_sp_d = rcs_pkg::SP_DEFAULT;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sw_owns_q <= 1'b0;
         sw_sp_q <= rcs_pkg::SP_DEFAULT;
      end else if (take && cmd.cmd_vset) begin
         sw_owns_q <= 1'b1;
         sw_sp_q <= cmd.vset;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         setpoint <= rcs_pkg::SP_DEFAULT;
      end else begin
         setpoint <= sw_owns_q ? sw_sp_q : pin_sp_d;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sw_off_q <= 1'b0;
      end else if (take && cmd.cmd_off) begin
         sw_off_q <= 1'b1;
      end else if (take && cmd.cmd_on) begin
         sw_off_q <= 1'b0;
      end
   end

   assign slot_engaged = slot_pos.valid;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_on_q <= 1'b0;
      end else begin
         // On/off and interlock; interlock gates hot plug
         out_on_q <= slot_engaged && !ilk_sync_q[1] && !sw_off_q && !ot_sd_q
                     && (mode_sync_q[1] || !onoff_sync_q[1]);
      end
   end
   assign main_out_en = out_on_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pg_cnt_q <= '0;
         pg_tgl_q <= 1'b0;
      end else if (!overload) begin
         pg_cnt_q <= '0;
         pg_tgl_q <= 1'b0;
      end else if (pg_cnt_q == 32'(PG_PULSE_CYC - 1)) begin
         pg_cnt_q <= '0;
         pg_tgl_q <= !pg_tgl_q;
      end else begin
         pg_cnt_q <= pg_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pg_q <= 1'b0;
      end else begin
         pg_q <= out_on_q && out_in_reg && !out_near_drop && !(overload && pg_tgl_q);
      end
   end
   assign power_good_warn_n = pg_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         otw_cnt_q <= '0;
         otw_q <= 1'b0;
         ot_sd_q <= 1'b0;
      end else if (!overtemp) begin
         otw_cnt_q <= '0;
         otw_q <= 1'b0;
         ot_sd_q <= 1'b0;
      end else begin
         otw_q <= 1'b1;
         if (otw_cnt_q == 36'(OTW_LEAD_CYC - 1)) begin
            ot_sd_q <= 1'b1;
         end else begin
            otw_cnt_q <= otw_cnt_q + 36'h1;
         end
      end
   end
   assign overtemp_warn_n = !otw_q;
   assign overtemp_shutdown = ot_sd_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= |faults;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cap_q <= 1'b0;
      end else begin
         cap_q <= high_line;
      end
   end
   assign fault_n = !fault_q;
   assign power_limit_indicator = cap_q;

   // Latched alert, set wins over clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         alert_q <= 1'b0;
      end else if (state_change || comm_error || invalid_cmd) begin
         alert_q <= 1'b1;
      end else if (take && cmd.cmd_clear) begin
         alert_q <= 1'b0;
      end
   end

   assign combined_alert_n = !alert_q && selector_alert_n;

   assign module_present = 1'b0;
endmodule : rcs_top

// [bench/rcs_checker.sv]
// Assertion checker bound to the rectifier control and status top
module rcs_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire rcs_pkg::rcs_cmd_t cmd,
   input wire logic interlock_n,
   input wire logic out_near_drop,
   input wire logic overtemp,
   input wire rcs_pkg::rcs_fault_t faults,
   input wire logic selector_alert_n,
   input wire logic cmd_accept,
   input wire logic invalid_cmd,
   input wire logic [rcs_pkg::SP_W-1:0] setpoint,
   input wire logic main_out_en,
   input wire logic power_good_warn_n,
   input wire logic fault_n,
   input wire logic overtemp_warn_n,
   input wire logic combined_alert_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_bc_wr;
      cmd.valid && !cmd.rd && cmd.addr == 7'h00;
   endsequence
   sequence s_bc_rd;
      cmd.valid && cmd.rd && cmd.addr == 7'h00;
   endsequence
   property p_bc_rd;
      s_bc_rd |=> invalid_cmd && !cmd_accept;
   endproperty
   a_bc_rd: assert property (p_bc_rd) else $error("broadcast read answered");
   property p_bc_wr;
      s_bc_wr |=> cmd_accept && !invalid_cmd;
   endproperty
   a_bc_wr: assert property (p_bc_wr) else $error("broadcast write dropped");
   property p_vset;
      s_bc_wr ##0 cmd.cmd_vset |-> ##2 setpoint == $past(cmd.vset, 2);
   endproperty
   a_vset: assert property (p_vset) else $error("setpoint not taken");
   property p_lock_off;
      interlock_n [*3] |=> !main_out_en;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("output on without lock");
   property p_pg_drop;
      out_near_drop |=> !power_good_warn_n;
   endproperty
   a_pg_drop: assert property (p_pg_drop) else $error("power good late");
   property p_fault;
      faults != '0 |-> ##[1:3] !fault_n;
   endproperty
   a_fault: assert property (p_fault) else $error("fault not shown");
   property p_otw;
      overtemp |=> !overtemp_warn_n;
   endproperty
   a_otw: assert property (p_otw) else $error("warning late");
   property p_sel_alert;
      !selector_alert_n |-> !combined_alert_n;
   endproperty
   a_sel_alert: assert property (p_sel_alert) else $error("selector alert lost");
   property p_inv_alert;
      invalid_cmd |=> !combined_alert_n;
   endproperty
   a_inv_alert: assert property (p_inv_alert) else $error("alert not latched");
endmodule : rcs_checker
bind rcs_top rcs_checker u_chk (.clk, .arst_n, .cmd, .interlock_n, .out_near_drop, .overtemp,
   .faults, .selector_alert_n, .cmd_accept, .invalid_cmd, .setpoint, .main_out_en,
   .power_good_warn_n, .fault_n, .overtemp_warn_n, .combined_alert_n);

// [bench/rcs_host_model.sv]
// Host controller model issuing single-cycle commands
module rcs_host_model (
   input wire logic clk,
   input wire logic cmd_accept,
   input wire logic invalid_cmd,
   output rcs_pkg::rcs_cmd_t cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cmd = '0;
   task automatic send(input logic rd, input logic [6:0] addr, input logic [3:0] op,
         input logic [9:0] vset, output logic acc, output logic inv);
      @(posedge clk);
      cmd <= {1'b1, rd, addr, op, vset};
      @(posedge clk);
      cmd <= {1'b0, ~cmd[21:0]};
      @(posedge clk);
      acc = cmd_accept;
      inv = invalid_cmd;
   endtask : send
endmodule : rcs_host_model

// [bench/rcs_top_tb_top.sv]
// Testbench of the rectifier control and status logic
module rcs_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, arst_n = 1'b0, rs485_mode = 1'b0, on_off_n = 1'b1, interlock_n = 1'b1;
   logic out_in_reg = 1'b1, out_near_drop = 1'b0, overload = 1'b0, overtemp = 1'b0;
   logic high_line = 1'b0, state_change = 1'b0, comm_error = 1'b0, selector_alert_n = 1'b1;
   logic [3:0] i2c_pos_bits = 4'h5;
   logic [7:0] unit_position_level = 8'h9c, slot_position_level = 8'h00, vprog_level = 8'h00;
   logic [9:0] shelf_position_level = 10'h019;
   logic [9:0] setpoint;
   logic [15:0] hi;
   rcs_pkg::rcs_fault_t faults = '0;
   rcs_pkg::rcs_cmd_t cmd;
   rcs_pkg::rcs_pos_t bay_position_level, slot_pos, shelf_pos;
   logic cmd_accept, invalid_cmd, main_out_en, overtemp_shutdown, power_good_warn_n, fault_n;
   logic overtemp_warn_n, power_limit_indicator, combined_alert_n, module_present;
   int err_total = 0, num_checks = 0;
   always #2.5 clk = ~clk;
   rcs_top #(.PG_PULSE_CYC(8), .OTW_LEAD_CYC(20)) dut (.clk, .arst_n, .rs485_mode,
      .i2c_pos_bits, .unit_position_level, .slot_position_level, .shelf_position_level,
      .vprog_level, .on_off_n, .interlock_n, .cmd, .out_in_reg, .out_near_drop, .overload,
      .faults, .overtemp, .high_line, .state_change, .comm_error, .selector_alert_n,
      .bay_position_level, .slot_pos, .shelf_pos, .cmd_accept, .invalid_cmd, .setpoint,
      .main_out_en, .overtemp_shutdown, .power_good_warn_n, .fault_n, .overtemp_warn_n,
      .power_limit_indicator, .combined_alert_n, .module_present);
   rcs_host_model host (.clk, .cmd_accept, .invalid_cmd, .cmd);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask : w
   task automatic cmdx(input logic r, input logic [6:0] a, input logic [3:0] op,
         input logic [9:0] v, input logic [1:0] exp);
      logic acc;
      logic inv;
      host.send(r, a, op, v, acc, inv);
      chk({acc, inv}, exp);
   endtask : cmdx
   task automatic final_report;
      if (err_total == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      final_report;
   end
   initial begin
      w(10);
      arst_n <= 1'b1;
      w(5);
      chk(setpoint, rcs_pkg::SP_MIN);
      chk({fault_n, overtemp_warn_n, combined_alert_n, module_present}, 4'he);
      vprog_level <= 8'he8;
      w(5);
      chk(setpoint, rcs_pkg::SP_MIN + rcs_pkg::SP_SPAN);
      vprog_level <= 8'hff;
      w(5);
      chk(setpoint, rcs_pkg::SP_DEFAULT);
      for (int i = 0; i < 10; i++) begin
         slot_position_level <= rcs_pkg::POS_NOM[i];
         unit_position_level <= rcs_pkg::POS_NOM[i];
         shelf_position_level <= 10'(25 * (i + 1));
         w(4);
         chk({slot_pos, bay_position_level}, {2{1'b1, 4'(i + 1)}});
         chk(shelf_pos, {1'b1, 4'(i + 1)});
      end
      interlock_n <= 1'b0;
      on_off_n <= 1'b0;
      w(5);
      chk({main_out_en, power_good_warn_n}, 2'b11);
      interlock_n <= 1'b1;
      w(4);
      chk(main_out_en, 1'b0);
      interlock_n <= 1'b0;
      on_off_n <= 1'b1;
      w(4);
      chk(main_out_en, 1'b0);
      on_off_n <= 1'b0;
      slot_position_level <= 8'hff;
      shelf_position_level <= 10'h000;
      w(5);
      chk({main_out_en, slot_pos.valid, shelf_pos.valid}, 3'b000);
      slot_position_level <= 8'h00;
      shelf_position_level <= 10'h0fa;
      out_near_drop <= 1'b1;
      w(5);
      chk({main_out_en, power_good_warn_n}, 2'b10);
      out_near_drop <= 1'b0;
      overload <= 1'b1;
      hi = '0;
      w(3);
      repeat (48) begin
         @(posedge clk);
         hi += power_good_warn_n;
      end
      chk(hi, 16'h0018);
      overload <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         faults <= 4'(1 << i);
         w(4);
         chk(fault_n, 1'b0);
      end
      faults <= '0;
      overtemp <= 1'b1;
      w(18);
      chk({overtemp_warn_n, overtemp_shutdown, main_out_en}, 3'b001);
      w(6);
      chk({overtemp_warn_n, overtemp_shutdown, main_out_en}, 3'b010);
      overtemp <= 1'b0;
      high_line <= 1'b1;
      w(6);
      chk({overtemp_warn_n, overtemp_shutdown, main_out_en}, 3'b101);
      chk(power_limit_indicator, 1'b1);
      high_line <= 1'b0;
      w(3);
      chk(power_limit_indicator, 1'b0);
      cmdx(1'b0, 7'h45, 4'h8, 10'h1f4, 2'b10);
      vprog_level <= 8'h00;
      w(5);
      chk(setpoint, 10'h1f4);
      cmdx(1'b0, 7'h46, 4'h8, 10'h190, 2'b00);
      cmdx(1'b0, 7'h00, 4'h8, 10'h208, 2'b10);
      cmdx(1'b1, 7'h45, 4'h0, 10'h000, 2'b10);
      chk(setpoint, 10'h208);
      cmdx(1'b0, 7'h00, 4'h2, 10'h000, 2'b10);
      w(3);
      chk(main_out_en, 1'b0);
      cmdx(1'b0, 7'h00, 4'h4, 10'h000, 2'b10);
      w(3);
      chk(main_out_en, 1'b1);
      cmdx(1'b1, 7'h00, 4'h0, 10'h000, 2'b01);
      w(5);
      chk(combined_alert_n, 1'b0);
      cmdx(1'b0, 7'h45, 4'h1, 10'h000, 2'b10);
      w(2);
      chk(combined_alert_n, 1'b1);
      state_change <= 1'b1;
      comm_error <= 1'b1;
      w(1);
      state_change <= 1'b0;
      comm_error <= 1'b0;
      w(3);
      chk(combined_alert_n, 1'b0);
      selector_alert_n <= 1'b0;
      rs485_mode <= 1'b1;
      on_off_n <= 1'b1;
      w(5);
      chk({main_out_en, combined_alert_n}, 2'b10);
      selector_alert_n <= 1'b1;
      cmdx(1'b0, 7'h0a, 4'h8, 10'h1c2, 2'b10);
      cmdx(1'b0, 7'h45, 4'h8, 10'h1c2, 2'b00);
      arst_n <= 1'b0;
      w(2);
      arst_n <= 1'b1;
      w(5);
      chk(setpoint, rcs_pkg::SP_MIN);
      final_report;
   end
endmodule : rcs_top_tb_top
